/* design/duty_ramp_limiter.sv */
// Per-output duty-cycle ramp limiter
`timescale 1ns/1ns
module duty_ramp_limiter
	import fan_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic upd,
	input wire logic ramp_en,
	input wire logic [2:0] step_code,
	input wire logic [7:0] target,
	output logic [7:0] duty
);
	logic [7:0] duty_r;
	logic [7:0] duty_nxt;
	logic [7:0] step;

	assign duty = duty_r;
	assign step = step_slots(step_code); // R18

	always_comb begin
		duty_nxt = duty_r;
		if (upd) begin
			if (!ramp_en) begin
				duty_nxt = target; // R13
			end else if (target > duty_r) begin
				duty_nxt = (target - duty_r > step) ? duty_r + step : target; // R14 R19
			end else if (target < duty_r) begin
				duty_nxt = (duty_r - target > step) ? duty_r - step : target; // R14
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) duty_r <= 8'h00;
		else duty_r <= duty_nxt;
	end

	property p_direct;
		@(posedge clk_sys) disable iff (!rst_n) upd && !ramp_en |=> duty_r == $past(target);
	endproperty
	a_direct: assert property (p_direct) else $error("Duty did not follow target"); // R13

	property p_step;
		@(posedge clk_sys) disable iff (!rst_n) upd && ramp_en |=>
			(duty_r == $past(target))
			|| ($past(target) > $past(duty_r) && duty_r == $past(duty_r) + $past(step))
			|| ($past(target) < $past(duty_r) && duty_r == $past(duty_r) - $past(step));
	endproperty
	a_step: assert property (p_step) else $error("Ramp step wrong"); // R14

	property p_idle;
		@(posedge clk_sys) disable iff (!rst_n) !upd |=> $stable(duty_r);
	endproperty
	a_idle: assert property (p_idle) else $error("Duty moved without update"); // R14
endmodule // duty_ramp_limiter

/* design/dyn_fan_ctrl.sv */
// Dynamic fan-start temperature and duty ramp control, top level
// Notes on behaviour
// R1: Raise start temp only in quiet window
// R2: Start temp floor per temperature encoding
// R3: Increase clamped at channel high limit
// R4: Below start temp: fan held, no adjust
// R5: Three control bits enable alarm copy
// R6: Bit 4 copies remote 2 temperature
// R7: Bit 3 copies local temperature
// R8: Bit 2 copies remote 1 temperature
// R9: Copy disabled keeps software operating point
// R10: Bits 7..5 enable per-channel adjustment
// R11: Adjust from temp, point, limits
// R12: Disabled channel keeps start temp fixed
// R13: No ramp limit: duty follows target
// R14: Ramp limit: bounded step toward target
// R15: Ramp limiting independent per drive output
// R16: First acoustics bit 3 enables output A
// R17: Second acoustics bits 7, 3 enable B, C
// R18: Step code picks 1..48 slots
// R19: Duty spans 255 slots
// R20: Decrease every n, increase every 2n
// R21: Alarm sampled once per monitoring cycle
`timescale 1ns/1ns
module dyn_fan_ctrl
	import fan_pkg::*;
#(
	parameter int MON_DIV = MON_CYCLE_CLKS
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic thermal_alarm_pin_n,
	input wire logic ofs64_mode,
	input wire logic [7:0] temp_remote1,
	input wire logic [7:0] temp_local,
	input wire logic [7:0] temp_remote2,
	input wire logic [7:0] high_lim_remote1,
	input wire logic [7:0] high_lim_local,
	input wire logic [7:0] high_lim_remote2,
	input wire logic [7:0] low_lim_remote1,
	input wire logic [7:0] low_lim_local,
	input wire logic [7:0] low_lim_remote2,
	input wire logic tmin_ld,
	input wire logic [1:0] tmin_ld_sel,
	input wire logic [7:0] tmin_ld_val,
	output logic [7:0] start_temp_remote1,
	output logic [7:0] start_temp_local,
	output logic [7:0] start_temp_remote2,
	output logic [2:0] fan_hold,
	output logic mon_tick,
	input wire logic duty_upd,
	input wire logic [7:0] duty_target_a,
	input wire logic [7:0] duty_target_b,
	input wire logic [7:0] duty_target_c,
	output logic [7:0] fan_drive_out_a,
	output logic [7:0] fan_drive_out_b,
	output logic [7:0] fan_drive_out_c
);
	localparam int MON_W = $clog2(MON_DIV + 1);

	if (MON_DIV < 2) begin : g_div_check
		$error("MON_DIV must be at least 2");
	end

	// ----------------------------------------------------------------
	// Monitoring cycle divider
	// ----------------------------------------------------------------
	logic [MON_W-1:0] mon_cnt_r, mon_cnt_nxt;
	logic mon_tick_r, mon_tick_nxt;

	always_comb begin
		mon_tick_nxt = 1'b0;
		mon_cnt_nxt = mon_cnt_r + 1'b1;
		if (mon_cnt_r == MON_W'(MON_DIV - 1)) begin
			mon_cnt_nxt = '0;
			mon_tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mon_cnt_r <= '0;
			mon_tick_r <= 1'b0;
		end else begin
			mon_cnt_r <= mon_cnt_nxt;
			mon_tick_r <= mon_tick_nxt;
		end
	end

	assign mon_tick = mon_tick_r;

	// ----------------------------------------------------------------
	// Register bank and alarm copy
	// ----------------------------------------------------------------
	logic [7:0] op_r [3];
	logic [7:0] op_nxt [3];
	logic [7:0] dyn_ctrl_1_r, dyn_ctrl_1_nxt, dyn_ctrl_2_r, dyn_ctrl_2_nxt;
	logic [7:0] ramp_ctrl_1_r, ramp_ctrl_1_nxt, ramp_ctrl_2_r, ramp_ctrl_2_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [7:0] temp_ch [3];
	logic [2:0] copy_en, adj_en;
	logic alarm_now;

	assign temp_ch[0] = temp_remote1;
	assign temp_ch[1] = temp_local;
	assign temp_ch[2] = temp_remote2;
	assign copy_en = {dyn_ctrl_1_r[BIT_R2_COPY], dyn_ctrl_1_r[BIT_LOC_COPY], dyn_ctrl_1_r[BIT_R1_COPY]}; // R5
	assign adj_en = {dyn_ctrl_1_r[BIT_R2_ADJ], dyn_ctrl_1_r[BIT_LOC_ADJ], dyn_ctrl_1_r[BIT_R1_ADJ]}; // R10
	assign alarm_now = mon_tick_r && !thermal_alarm_pin_n; // R21

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			op_nxt[i] = op_r[i];
		end
		dyn_ctrl_1_nxt = dyn_ctrl_1_r;
		dyn_ctrl_2_nxt = dyn_ctrl_2_r;
		ramp_ctrl_1_nxt = ramp_ctrl_1_r;
		ramp_ctrl_2_nxt = ramp_ctrl_2_r;
		rdata_nxt = rdata_r;
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_OP_R1: op_nxt[0] = reg_wdata;
				ADDR_OP_LOC: op_nxt[1] = reg_wdata;
				ADDR_OP_R2: op_nxt[2] = reg_wdata;
				ADDR_DYN_CTRL_1: dyn_ctrl_1_nxt = reg_wdata;
				ADDR_DYN_CTRL_2: dyn_ctrl_2_nxt = reg_wdata;
				ADDR_RAMP_CTRL_1: ramp_ctrl_1_nxt = reg_wdata;
				ADDR_RAMP_CTRL_2: ramp_ctrl_2_nxt = reg_wdata;
				default: ;
			endcase
		end
		// Hardware copy wins over a software write in the same cycle
		for (int i = 0; i < 3; i++) begin
			if (alarm_now && copy_en[i]) op_nxt[i] = temp_ch[i]; // R6 R7 R8 R9
		end
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_OP_R1: rdata_nxt = op_r[0];
				ADDR_OP_LOC: rdata_nxt = op_r[1];
				ADDR_OP_R2: rdata_nxt = op_r[2];
				ADDR_DYN_CTRL_1: rdata_nxt = dyn_ctrl_1_r;
				ADDR_DYN_CTRL_2: rdata_nxt = dyn_ctrl_2_r;
				ADDR_RAMP_CTRL_1: rdata_nxt = ramp_ctrl_1_r;
				ADDR_RAMP_CTRL_2: rdata_nxt = ramp_ctrl_2_r;
				default: rdata_nxt = RDATA_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				op_r[i] <= OP_RESET;
			end
			dyn_ctrl_1_r <= CTRL_RESET;
			dyn_ctrl_2_r <= CTRL_RESET;
			ramp_ctrl_1_r <= CTRL_RESET;
			ramp_ctrl_2_r <= CTRL_RESET;
			rdata_r <= 8'h00;
		end else begin
			for (int i = 0; i < 3; i++) begin
				op_r[i] <= op_nxt[i];
			end
			dyn_ctrl_1_r <= dyn_ctrl_1_nxt;
			dyn_ctrl_2_r <= dyn_ctrl_2_nxt;
			ramp_ctrl_1_r <= ramp_ctrl_1_nxt;
			ramp_ctrl_2_r <= ramp_ctrl_2_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Start temperature channels
	// ----------------------------------------------------------------
	logic [7:0] high_ch [3];
	logic [7:0] low_ch [3];
	logic [7:0] tmin_ch [3];
	logic [2:0] cyc_ch [3];

	assign high_ch[0] = high_lim_remote1;
	assign high_ch[1] = high_lim_local;
	assign high_ch[2] = high_lim_remote2;
	assign low_ch[0] = low_lim_remote1;
	assign low_ch[1] = low_lim_local;
	assign low_ch[2] = low_lim_remote2;
	assign cyc_ch[0] = dyn_ctrl_2_r[CYC_R1_LSB +: 3]; // R20
	assign cyc_ch[1] = dyn_ctrl_2_r[CYC_LOC_LSB +: 3]; // R20
	assign cyc_ch[2] = {dyn_ctrl_2_r[CYC_R2_HI_LSB +: 2], dyn_ctrl_1_r[BIT_R2_CYC_LO]}; // R20

	for (genvar g = 0; g < 3; g++) begin : g_chan
		start_temp_adjust u_adj (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.mon_tick(mon_tick_r),
			.adj_en(adj_en[g]),
			.ofs64_mode(ofs64_mode),
			.temp(temp_ch[g]),
			.op_point(op_r[g]),
			.high_lim(high_ch[g]),
			.low_lim(low_ch[g]),
			.cyc_code(cyc_ch[g]),
			.tmin_ld(tmin_ld && tmin_ld_sel == 2'(g)),
			.tmin_ld_val(tmin_ld_val),
			.tmin(tmin_ch[g]),
			.below_start(fan_hold[g])
		);
	end

	assign start_temp_remote1 = tmin_ch[0];
	assign start_temp_local = tmin_ch[1];
	assign start_temp_remote2 = tmin_ch[2];

	// ----------------------------------------------------------------
	// Duty ramp limiters, one per drive output
	// ----------------------------------------------------------------
	logic [2:0] ramp_en;
	logic [2:0] step_code [3];
	logic [7:0] target_ch [3];
	logic [7:0] duty_ch [3];

	assign ramp_en = {ramp_ctrl_2_r[RAMP_C_EN], ramp_ctrl_2_r[RAMP_B_EN], ramp_ctrl_1_r[RAMP_A_EN]}; // R16 R17
	assign step_code[0] = ramp_ctrl_1_r[RAMP_A_STEP_LSB +: 3]; // R18
	assign step_code[1] = ramp_ctrl_2_r[RAMP_B_STEP_LSB +: 3]; // R18
	assign step_code[2] = ramp_ctrl_2_r[RAMP_C_STEP_LSB +: 3]; // R18
	assign target_ch[0] = duty_target_a;
	assign target_ch[1] = duty_target_b;
	assign target_ch[2] = duty_target_c;

	for (genvar g = 0; g < 3; g++) begin : g_drive
		duty_ramp_limiter u_ramp ( // R15
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.upd(duty_upd),
			.ramp_en(ramp_en[g]),
			.step_code(step_code[g]),
			.target(target_ch[g]),
			.duty(duty_ch[g])
		);
	end

	assign fan_drive_out_a = duty_ch[0];
	assign fan_drive_out_b = duty_ch[1];
	assign fan_drive_out_c = duty_ch[2];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_copy_r2;
		@(posedge clk_sys) disable iff (!rst_n) mon_tick_r && !thermal_alarm_pin_n && dyn_ctrl_1_r[BIT_R2_COPY]
			|=> op_r[2] == $past(temp_remote2);
	endproperty
	a_copy_r2: assert property (p_copy_r2) else $error("Remote 2 point not copied"); // R6

	property p_copy_loc;
		@(posedge clk_sys) disable iff (!rst_n) mon_tick_r && !thermal_alarm_pin_n && dyn_ctrl_1_r[BIT_LOC_COPY]
			|=> op_r[1] == $past(temp_local);
	endproperty
	a_copy_loc: assert property (p_copy_loc) else $error("Local point not copied"); // R7

	property p_copy_r1;
		@(posedge clk_sys) disable iff (!rst_n) mon_tick_r && !thermal_alarm_pin_n && dyn_ctrl_1_r[BIT_R1_COPY]
			|=> op_r[0] == $past(temp_remote1);
	endproperty
	a_copy_r1: assert property (p_copy_r1) else $error("Remote 1 point not copied"); // R8

	property p_ignore;
		@(posedge clk_sys) disable iff (!rst_n) !dyn_ctrl_1_r[BIT_R1_COPY] && !reg_wr |=> $stable(op_r[0]);
	endproperty
	a_ignore: assert property (p_ignore) else $error("Point changed with copy off"); // R9

	property p_no_tick_copy;
		@(posedge clk_sys) disable iff (!rst_n) !mon_tick_r && !reg_wr |=> $stable(op_r[1]) && $stable(op_r[2]);
	endproperty
	a_no_tick_copy: assert property (p_no_tick_copy) else $error("Copy outside monitoring tick"); // R21

	property p_tick_gap;
		@(posedge clk_sys) disable iff (!rst_n) mon_tick_r |=> !mon_tick_r;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("Monitoring tick too long"); // R21
endmodule // dyn_fan_ctrl

/* design/start_temp_adjust.sv */
// One channel's dynamic fan-start temperature loop
`timescale 1ns/1ns
module start_temp_adjust
	import fan_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic mon_tick,
	input wire logic adj_en,
	input wire logic ofs64_mode,
	input wire logic [7:0] temp,
	input wire logic [7:0] op_point,
	input wire logic [7:0] high_lim,
	input wire logic [7:0] low_lim,
	input wire logic [2:0] cyc_code,
	input wire logic tmin_ld,
	input wire logic [7:0] tmin_ld_val,
	output logic [7:0] tmin,
	output logic below_start
);
	logic [7:0] tmin_r, tmin_nxt, prev_r, prev_nxt;
	logic [11:0] cnt_r, cnt_nxt, short_len;
	logic below_r, below_nxt, short_hit, long_hit;
	logic signed [11:0] t, tm, op, hi, lo, pv, nv, flr;

	assign tmin = tmin_r;
	assign below_start = below_r;
	assign short_len = SHORT_BASE << cyc_code;
	assign t = to_deg(temp, ofs64_mode);
	assign tm = to_deg(tmin_r, ofs64_mode);
	assign op = to_deg(op_point, ofs64_mode);
	assign hi = to_deg(high_lim, ofs64_mode);
	assign lo = to_deg(low_lim, ofs64_mode);
	assign pv = to_deg(prev_r, ofs64_mode);
	assign flr = ofs64_mode ? FLOOR_OFS64 : FLOOR_TWOS;
	assign short_hit = (((cnt_r + 12'h001) & (short_len - 12'h001)) == 12'h000); // R20
	assign long_hit = (((cnt_r + 12'h001) & ((short_len << 1) - 12'h001)) == 12'h000); // R20

	always_comb begin
		tmin_nxt = tmin_r;
		prev_nxt = prev_r;
		below_nxt = below_r;
		cnt_nxt = cnt_r;
		nv = tm;
		if (mon_tick) begin
			below_nxt = t < tm; // R4
			cnt_nxt = adj_en ? cnt_r + 12'h001 : 12'h000; // R12
			if (adj_en && t >= tm) begin // R4 R11
				if (short_hit && t > op && t > pv) nv = nv - ((t - pv) <<< 1);
				if (long_hit && t > op) nv = nv - 12'sh001;
				else if (long_hit && t > tm && t < lo && tm < hi && tm < op) nv = nv + 12'sh001; // R1
				if (nv > tm && nv > hi) nv = hi; // R3
				if (nv < flr) nv = flr; // R2
				tmin_nxt = from_deg(nv, ofs64_mode);
			end
			if (short_hit) prev_nxt = temp;
		end
		if (tmin_ld) tmin_nxt = tmin_ld_val;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tmin_r <= 8'h00;
			prev_r <= 8'h00;
			below_r <= 1'b0;
			cnt_r <= 12'h000;
		end else begin
			tmin_r <= tmin_nxt;
			prev_r <= prev_nxt;
			below_r <= below_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	property p_hold_off;
		@(posedge clk_sys) disable iff (!rst_n) !adj_en && !tmin_ld |=> $stable(tmin_r);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("Start temp moved while disabled"); // R12

	property p_rise_cond;
		@(posedge clk_sys) disable iff (!rst_n) !tmin_ld && mon_tick && (tm + 12'sh001 == to_deg(tmin_nxt,
			ofs64_mode)) |-> long_hit && t > tm && t < lo && tm < hi && tm < op;
	endproperty
	a_rise_cond: assert property (p_rise_cond) else $error("Start temp rose without cause"); // R1

	property p_below;
		@(posedge clk_sys) disable iff (!rst_n) !tmin_ld && mon_tick && t < tm |=> $stable(tmin_r);
	endproperty
	a_below: assert property (p_below) else $error("Adjusted below start temp"); // R4

	property p_floor;
		@(posedge clk_sys) disable iff (!rst_n) mon_tick && !tmin_ld && adj_en && t >= tm |=>
			to_deg(tmin_r, ofs64_mode) >= flr;
	endproperty
	a_floor: assert property (p_floor) else $error("Start temp under floor"); // R2

	property p_high;
		@(posedge clk_sys) disable iff (!rst_n) mon_tick && !tmin_ld && nv > tm |-> nv <= hi;
	endproperty
	a_high: assert property (p_high) else $error("Start temp rose over high limit"); // R3
endmodule // start_temp_adjust

/* shared/fan_pkg.sv */
// Constants and helpers shared by the fan start-temperature and ramp logic
package fan_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_OP_R1 = 8'h33;
	localparam logic [7:0] ADDR_OP_LOC = 8'h34;
	localparam logic [7:0] ADDR_OP_R2 = 8'h35;
	localparam logic [7:0] ADDR_DYN_CTRL_1 = 8'h36;
	localparam logic [7:0] ADDR_DYN_CTRL_2 = 8'h37;
	localparam logic [7:0] ADDR_RAMP_CTRL_1 = 8'h62;
	localparam logic [7:0] ADDR_RAMP_CTRL_2 = 8'h63;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_RESET = 8'hA4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_R2_ADJ = 7;
	localparam int BIT_LOC_ADJ = 6;
	localparam int BIT_R1_ADJ = 5;
	localparam int BIT_R2_COPY = 4;
	localparam int BIT_LOC_COPY = 3;
	localparam int BIT_R1_COPY = 2;
	localparam int BIT_R2_CYC_LO = 0;
	localparam int CYC_R1_LSB = 0;
	localparam int CYC_LOC_LSB = 3;
	localparam int CYC_R2_HI_LSB = 6;
	localparam int RAMP_A_EN = 3;
	localparam int RAMP_A_STEP_LSB = 0;
	localparam int RAMP_B_EN = 7;
	localparam int RAMP_B_STEP_LSB = 4;
	localparam int RAMP_C_EN = 3;
	localparam int RAMP_C_STEP_LSB = 0;
	// ----------------------------------------------------------------
	// Temperature and timing
	// ----------------------------------------------------------------
	localparam logic signed [11:0] FLOOR_TWOS = -12'sh07F;
	localparam logic signed [11:0] FLOOR_OFS64 = -12'sh040;
	localparam logic signed [11:0] OFS64_BIAS = 12'sh040;
	localparam logic [7:0] SLOT_MAX = 8'hFF;
	localparam logic [11:0] SHORT_BASE = 12'h008;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MON_CYCLE_MS = 115;
	localparam int MON_CYCLE_CLKS = MON_CYCLE_MS * 1000000 / CLK_PERIOD_NS;

	function automatic logic [7:0] step_slots(input logic [2:0] code);
		logic [7:0] s;
		s = 8'h01;
		unique case (code)
			3'h0: s = 8'h01;
			3'h1: s = 8'h02;
			3'h2: s = 8'h03;
			3'h3: s = 8'h05;
			3'h4: s = 8'h08;
			3'h5: s = 8'h0C;
			3'h6: s = 8'h18;
			3'h7: s = 8'h30;
		endcase
		return s;
	endfunction

	function automatic logic signed [11:0] to_deg(input logic [7:0] t, input logic ofs64);
		return ofs64 ? $signed({4'h0, t}) - OFS64_BIAS : 12'(signed'(t));
	endfunction

	function automatic logic [7:0] from_deg(input logic signed [11:0] d, input logic ofs64);
		logic signed [11:0] v;
		v = ofs64 ? d + OFS64_BIAS : d;
		return v[7:0];
	endfunction
endpackage

/* verification/fan_far_side.sv */
// Far-side model: temperature channels and fan duty targets
`timescale 1ns/1ns
module fan_far_side (
	input wire logic clk_sys,
	output logic [7:0] temp_remote1,
	output logic [7:0] temp_local,
	output logic [7:0] temp_remote2,
	output logic duty_upd,
	output logic [7:0] duty_target_a,
	output logic [7:0] duty_target_b,
	output logic [7:0] duty_target_c
);
	initial begin
		temp_remote1 = 8'h00;
		temp_local = 8'h00;
		temp_remote2 = 8'h00;
		duty_upd = 1'b0;
		duty_target_a = 8'h00;
		duty_target_b = 8'h00;
		duty_target_c = 8'h00;
	end

	// ----------------------------------------------------------------
	// New readings from the three sensor channels
	// ----------------------------------------------------------------
	task automatic set_temps(input logic [7:0] r1, input logic [7:0] lc, input logic [7:0] r2);
		@(posedge clk_sys);
		#1;
		temp_remote1 = r1;
		temp_local = lc;
		temp_remote2 = r2;
	endtask

	// ----------------------------------------------------------------
	// One duty update; targets stay put afterwards
	// ----------------------------------------------------------------
	task automatic push_duty(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		@(posedge clk_sys);
		#1;
		duty_target_a = a;
		duty_target_b = b;
		duty_target_c = c;
		duty_upd = 1'b1;
		@(posedge clk_sys);
		#1;
		duty_upd = 1'b0;
	endtask
endmodule // fan_far_side

/* verification/test_dyn_fan_ctrl.sv */
// Self-checking bench for the dynamic fan control block
`timescale 1ns/1ns
module test_dyn_fan_ctrl;
	import fan_pkg::*;
	localparam int DIV = 20;
	localparam int LONG = 16 * DIV;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic alarm_n = 1'b1;
	logic ofs64 = 1'b0;
	logic tmin_ld = 1'b0;
	logic [1:0] ld_sel = 2'h3;
	logic [7:0] ld_val = 8'h00;
	logic [7:0] hi = 8'h18;
	logic [7:0] lo = 8'h28;
	logic [7:0] reg_rdata, t1, tl, t2, st1, stl, st2, ta, tb, tc, da, db, dc;
	logic [2:0] hold;
	logic mon_tick, duty_upd;
	logic [7:0] sl [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
	int n_errors = 0;
	int n_tests = 0;

	always #5 clk_sys = ~clk_sys;

	fan_far_side ff (.clk_sys(clk_sys), .temp_remote1(t1), .temp_local(tl), .temp_remote2(t2),
		.duty_upd(duty_upd), .duty_target_a(ta), .duty_target_b(tb), .duty_target_c(tc));

	dyn_fan_ctrl #(.MON_DIV(DIV)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.thermal_alarm_pin_n(alarm_n), .ofs64_mode(ofs64), .temp_remote1(t1), .temp_local(tl),
		.temp_remote2(t2), .high_lim_remote1(hi), .high_lim_local(hi), .high_lim_remote2(hi),
		.low_lim_remote1(lo), .low_lim_local(lo), .low_lim_remote2(lo), .tmin_ld(tmin_ld),
		.tmin_ld_sel(ld_sel), .tmin_ld_val(ld_val), .start_temp_remote1(st1), .start_temp_local(stl),
		.start_temp_remote2(st2), .fan_hold(hold), .mon_tick(mon_tick), .duty_upd(duty_upd),
		.duty_target_a(ta), .duty_target_b(tb), .duty_target_c(tc), .fan_drive_out_a(da),
		.fan_drive_out_b(db), .fan_drive_out_c(dc));

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		reg_addr = a;
		reg_rd = 1'b1;
		tick();
		reg_rd = 1'b0;
		chk(reg_rdata, exp, what);
		tick();
	endtask

	task automatic ld(input logic [1:0] s, input logic [7:0] v);
		ld_sel = s;
		ld_val = v;
		tmin_ld = 1'b1;
		tick();
		tmin_ld = 1'b0;
		ld_sel = 2'h3;
		tick();
	endtask

	task automatic wait_mon();
		int i;
		for (i = 0; i < 4 * DIV && mon_tick !== 1'b1; i++) begin
			tick();
		end
		chk({7'h00, mon_tick}, 8'h01, "monitor tick");
		tick();
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_regs();
		logic [7:0] a [8] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h62, 8'h63, 8'h40};
		logic [7:0] r [8] = '{8'hA4, 8'hA4, 8'hA4, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rd_chk(a[i], r[i], "reset value");
			wr(a[i], 8'h5A);
			rd_chk(a[i], (i == 7) ? 8'h00 : 8'h5A, "readback");
			if (i > 2) begin
				wr(a[i], 8'h00);
			end
		end
		$display("register test done");
	endtask

	task automatic test_alarm();
		ff.set_temps(8'h50, 8'h51, 8'h52);
		wr(8'h34, 8'h30);
		wr(8'h36, 8'h14);
		alarm_n = 1'b0;
		wait_mon();
		alarm_n = 1'b1;
		rd_chk(8'h33, 8'h50, "remote1 copy");
		rd_chk(8'h34, 8'h30, "local kept");
		rd_chk(8'h35, 8'h52, "remote2 copy");
		wr(8'h36, 8'h08);
		ff.set_temps(8'h60, 8'h61, 8'h62);
		alarm_n = 1'b0;
		wait_mon();
		alarm_n = 1'b1;
		rd_chk(8'h34, 8'h61, "local copy");
		rd_chk(8'h33, 8'h50, "remote1 kept");
		wr(8'h36, 8'h04);
		alarm_n = 1'b0;
		repeat (5) tick();
		alarm_n = 1'b1;
		wait_mon();
		rd_chk(8'h33, 8'h50, "off-tick alarm ignored");
		wr(8'h36, 8'h00);
		$display("alarm copy test done");
	endtask

	task automatic test_ramp();
		logic [2:0] k;
		for (int i = 0; i < 8; i++) begin
			k = 3'(i);
			wr(8'h62, 8'h00);
			wr(8'h63, 8'h00);
			ff.push_duty(8'h00, 8'h00, 8'h00);
			wr(8'h62, {5'h01, k});
			wr(8'h63, {k[0], k, 1'b1, ~k});
			ff.push_duty(8'hC8, 8'hC8, 8'hC8);
			chk(da, sl[k], "ramp a up");
			chk(db, k[0] ? sl[k] : 8'hC8, "ramp b up");
			chk(dc, sl[~k], "ramp c up");
			ff.push_duty(sl[k] + 8'h01, 8'h00, sl[~k]);
			chk(da, sl[k] + 8'h01, "ramp a lands");
			chk(db, 8'h00, "ramp b lands");
			chk(dc, sl[~k], "ramp c holds");
			ff.push_duty(8'h00, 8'hFF, 8'h00);
			chk(da, 8'h01, "ramp a down");
			chk(db, k[0] ? sl[k] : SLOT_MAX, "ramp b full");
		end
		$display("ramp test done");
	endtask

	task automatic test_dyn();
		ff.set_temps(8'h1E, 8'h1E, 8'h1E);
		wr(8'h33, 8'h30);
		ld(2'h0, 8'h14);
		ld(2'h1, 8'h05);
		wr(8'h36, 8'h20);
		repeat (10 * LONG) tick();
		chk(st1, 8'h18, "raise clamped at high");
		chk(stl, 8'h05, "disabled channel fixed");
		chk(st2, 8'h00, "remote2 untouched");
		lo = 8'h10;
		ld(2'h0, 8'h14);
		repeat (3 * LONG) tick();
		chk(st1, 8'h14, "held above low limit");
		lo = 8'h28;
		wr(8'h36, 8'h00);
		wait_mon();
		wr(8'h37, 8'h01);
		ld(2'h0, 8'h14);
		wr(8'h36, 8'h20);
		repeat (31) wait_mon();
		chk(st1, 8'h14, "no rise before long cycle");
		wait_mon();
		chk(st1, 8'h15, "rise on long cycle");
		wr(8'h37, 8'h00);
		ld(2'h0, 8'h28);
		repeat (2 * LONG) tick();
		chk(st1, 8'h28, "below start no adjust");
		chk({5'h00, hold}, 8'h01, "fan held");
		for (int m = 0; m < 2; m++) begin
			ofs64 = m[0];
			wr(8'h33, m[0] ? 8'h01 : 8'h80);
			ff.set_temps(m[0] ? 8'h02 : 8'h82, 8'h1E, 8'h1E);
			ld(2'h0, m[0] ? 8'h00 : 8'h81);
			repeat (2 * LONG) tick();
			chk(st1, m[0] ? 8'h00 : 8'h81, "floor");
		end
		wr(8'h36, 8'h00);
		$display("dynamic start test done");
	endtask

	// ----------------------------------------------------------------
	// Verdict and run control
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		test_regs();
		test_alarm();
		test_ramp();
		test_dyn();
		conclude();
	end
endmodule // test_dyn_fan_ctrl
